// ===== hdl/pcr_config_rom.sv
`timescale 1ns/1ps
// config header slice and rom target path
module pcr_config_rom
    import pcr_pkg::*;
(
    input wire logic i_clk, // bus clock, 125 MHz
    input wire logic i_nrst, // bus reset, active low, async
    // configuration access port
    input wire logic i_cfg_wr, // config write strobe, pulse
    input wire logic i_cfg_rd, // config read strobe, pulse
    input wire logic [7:0] i_cfg_addr, // byte offset, dword aligned
    input wire logic [3:0] i_cfg_be, // byte enables, active high
    input wire logic [31:0] i_cfg_wdata, // write data
    output logic [31:0] o_cfg_rdata, // read data
    output logic o_cfg_ack, // access done, pulse
    input wire logic i_mem_space_en, // memory space enable
    // bus target pins
    input wire logic i_frame_n, // frame, active low
    input wire logic i_irdy_n, // initiator ready, active low
    input wire logic [31:0] i_ad, // address/data in
    input wire logic [3:0] i_cbe_n, // command/byte enables in
    output logic [31:0] o_ad, // read data out
    output logic o_ad_oe, // drive enable for ad
    output logic o_devsel_n, // device select, active low
    output logic o_trdy_n, // target ready, active low
    output logic o_stop_n, // stop, active low
    output logic o_tgt_oe, // target pin drive enable
    // memory port to the rom
    output logic o_mp_req, // byte request, level
    output logic o_mp_we, // write qualifier
    output logic [ROM_ADDR_W-1:0] o_mp_addr, // byte address
    output logic [7:0] o_mp_wdata, // write byte
    input wire logic i_mp_ack, // byte done, pulse
    input wire logic [7:0] i_mp_rdata, // read byte
    // register outputs
    output logic [31:MEM_BASE_LSB] o_mem_base_bits, // window base
    output logic [7:0] o_irq_line_value, // interrupt line store
    output logic o_mem_read_cmd_en, // master read command select
    output logic o_ext_block_slow_timing, // slow external sram cycle
    output logic o_ext_block_parity_en, // external sram parity check
    output logic o_parity_test_force, // force even parity for test
    output logic o_dual_addr_en, // dual address cycles allowed
    output logic o_term_power_polarity // termination power polarity
);
    import pcr_pkg::*;

    // ************************************************************
    // reset release
    // ************************************************************
    logic rst_meta_q;
    logic rst_n;

    // assert at once, release two edges later to avoid metastable exits
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    // ************************************************************
    // configuration registers
    // ************************************************************
    logic [31:MEM_BASE_LSB] mem_base_q;
    logic [31:ROM_BASE_LSB] rom_base_q;
    logic rom_enable_q;
    logic [7:0] irq_line_q;
    logic [7:0] feature_q;
    logic [7:0] cfg_addr_q;
    logic [31:0] rd_mux;
    logic hit_mem_base;
    logic hit_rom;
    logic hit_irq;
    logic hit_feat;

    assign hit_mem_base = i_cfg_addr == OFF_MEM_BASE;
    assign hit_rom = i_cfg_addr == OFF_ROM_BASE;
    assign hit_irq = i_cfg_addr == OFF_IRQ;
    assign hit_feat = i_cfg_addr == OFF_FEATURE;

    // memory base: only the 4 KB placement bits are stored
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_base_q <= MEM_BASE_RST;
        end else if (i_cfg_wr && hit_mem_base) begin
            if (i_cfg_be[1]) mem_base_q[15:12] <= i_cfg_wdata[15:12]; // RULE_01
            if (i_cfg_be[2]) mem_base_q[23:16] <= i_cfg_wdata[23:16]; // RULE_01
            if (i_cfg_be[3]) mem_base_q[31:24] <= i_cfg_wdata[31:24]; // RULE_01
        end
    end

    // rom base and enable; size bits unstored, read zero
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            rom_base_q <= ROM_BASE_RST; // RULE_03
            rom_enable_q <= 1'b0; // RULE_03
        end else if (i_cfg_wr && hit_rom) begin
            if (i_cfg_be[0]) rom_enable_q <= i_cfg_wdata[0];
            if (i_cfg_be[1]) rom_base_q[15] <= i_cfg_wdata[15]; // RULE_04
            if (i_cfg_be[2]) rom_base_q[23:16] <= i_cfg_wdata[23:16]; // RULE_04
            if (i_cfg_be[3]) rom_base_q[31:24] <= i_cfg_wdata[31:24]; // RULE_04
        end
    end

    // interrupt line: plain store, never decoded here
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_line_q <= IRQ_LINE_RST;
        end else if (i_cfg_wr && hit_irq && i_cfg_be[0]) begin
            irq_line_q <= i_cfg_wdata[7:0]; // RULE_13
        end
    end

    // feature config: writable any time, only the bus reset clears it
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            feature_q <= FEATURE_RST; // RULE_18
        end else if (i_cfg_wr && hit_feat && i_cfg_be[0]) begin
            feature_q <= i_cfg_wdata[7:0]; // RULE_18
        end
    end

    // read mux: fixed fields are constants, writes cannot stick
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (1'b1)
            hit_mem_base: rd_mux[31:MEM_BASE_LSB] = mem_base_q; // RULE_02
            hit_rom: rd_mux = {rom_base_q, 14'h0000, rom_enable_q}; // RULE_04
            hit_irq: rd_mux = {MAX_LAT_VALUE, MIN_GNT_VALUE, // RULE_16
                               IRQ_PIN_VALUE, irq_line_q}; // RULE_14 RULE_15
            hit_feat: rd_mux[7:0] = feature_q; // RULE_19
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // read data registered; unmapped offsets answer zero
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_cfg_rdata <= 32'h0000_0000;
            o_cfg_ack <= 1'b0;
            cfg_addr_q <= 8'h00;
        end else begin
            o_cfg_ack <= i_cfg_rd || i_cfg_wr;
            cfg_addr_q <= i_cfg_addr;
            if (i_cfg_rd) o_cfg_rdata <= rd_mux;
        end
    end

    assign o_mem_base_bits = mem_base_q;
    assign o_irq_line_value = irq_line_q;
    assign o_mem_read_cmd_en = feature_q[FC_MEM_READ_CMD];
    assign o_ext_block_slow_timing = feature_q[FC_SLOW_TIMING];
    assign o_ext_block_parity_en = feature_q[FC_PARITY_EN];
    assign o_parity_test_force = feature_q[FC_PARITY_FORCE];
    assign o_dual_addr_en = feature_q[FC_DUAL_ADDR];
    assign o_term_power_polarity = feature_q[FC_TERM_POL];

    // ************************************************************
    // target decode
    // ************************************************************
    pcr_state_t st_q;
    logic frame_prev_n_q;
    logic wr_q;
    logic [ROM_ADDR_W-1:2] addr_q;
    logic start;
    logic is_rd;
    logic is_wr;
    logic rom_claim;
    logic alias_hit;
    logic be_bad;
    logic [3:0] be;
    logic [1:0] lane;
    logic [7:0] wbyte;
    logic seq_start;
    logic seq_done;
    logic [31:0] seq_rdata;

    assign is_rd = i_cbe_n == CMD_MEM_RD || i_cbe_n == CMD_MEM_RD_MULT
                   || i_cbe_n == CMD_MEM_RD_LINE;
    assign is_wr = i_cbe_n == CMD_MEM_WR || i_cbe_n == CMD_MEM_WR_INV;
    assign start = st_q == ST_IDLE && !i_frame_n && frame_prev_n_q;
    // both enables needed, else the cycle is ignored
    assign rom_claim = rom_enable_q && i_mem_space_en && (is_rd || is_wr)
                       && i_ad[31:ROM_DEC_LSB] == rom_base_q[31:ROM_DEC_LSB]; // RULE_05
    // windows overlap when both bases match
    assign alias_hit = mem_base_q == {rom_base_q, 3'b000}; // RULE_06
    assign be = ~i_cbe_n;
    assign be_bad = wr_q && !$onehot(be); // RULE_11
    assign seq_start = st_q == ST_CLAIM && !i_irdy_n && !alias_hit
                       && !be_bad;

    // single enabled lane to low address bits
    always_comb begin
        lane = 2'd0;
        wbyte = i_ad[7:0];
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                lane = 2'(i); // RULE_10
                wbyte = i_ad[i*8 +: 8];
            end
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_prev_n_q <= 1'b1;
        end else begin
            frame_prev_n_q <= i_frame_n;
        end
    end

    // address capture; bits 1-0 are generated
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_q <= '0;
            wr_q <= 1'b0;
        end else if (start) begin
            addr_q <= i_ad[ROM_ADDR_W-1:2]; // RULE_07
            wr_q <= is_wr;
        end
    end

    // ************************************************************
    // target state machine
    // ************************************************************
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ST_IDLE;
        end else begin
            unique case (st_q)
                ST_IDLE: begin
                    if (start && rom_claim) st_q <= ST_CLAIM; // RULE_05
                end
                ST_CLAIM: begin
                    if (alias_hit) st_q <= ST_ABORT; // RULE_06
                    else if (!i_irdy_n && be_bad) st_q <= ST_ABORT; // RULE_11
                    else if (!i_irdy_n) st_q <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (seq_done) st_q <= ST_XFER; // RULE_07 RULE_10
                end
                ST_XFER: begin
                    // one phase, then cut the burst
                    if (!i_irdy_n) begin
                        st_q <= i_frame_n ? ST_IDLE : ST_STOPW; // RULE_09
                    end
                end
                ST_STOPW: begin
                    if (i_frame_n) st_q <= ST_IDLE; // RULE_10
                end
                ST_ABORT: begin
                    if (i_frame_n) st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // read word held through the data phase
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_ad <= 32'h0000_0000;
        end else if (seq_done) begin
            o_ad <= seq_rdata; // RULE_08
        end
    end

    // pins follow the state; trdy only once data is ready
    assign o_devsel_n = !(st_q inside {ST_CLAIM, ST_WAIT, ST_XFER, ST_STOPW});
    assign o_trdy_n = st_q != ST_XFER; // RULE_07
    assign o_stop_n = !(st_q inside {ST_XFER, ST_STOPW, ST_ABORT}); // RULE_09
    assign o_tgt_oe = st_q != ST_IDLE;
    assign o_ad_oe = !wr_q && (st_q inside {ST_WAIT, ST_XFER});

    // rom path never masters the bus: grant length is moot
    pcr_rom_seq u_seq (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_start(seq_start), // RULE_17
        .i_write(wr_q),
        .i_addr(addr_q),
        .i_lane(lane),
        .i_wdata(wbyte),
        .o_done(seq_done),
        .o_rdata(seq_rdata),
        .o_mp_req(o_mp_req),
        .o_mp_we(o_mp_we),
        .o_mp_addr(o_mp_addr),
        .o_mp_wdata(o_mp_wdata),
        .i_mp_ack(i_mp_ack),
        .i_mp_rdata(i_mp_rdata)
    );

    // ************************************************************
    // checks
    // ************************************************************
    mem_base_low_a: assert property (@(posedge i_clk) disable iff (!rst_n) // RULE_02
        o_cfg_ack && $past(i_cfg_rd) && cfg_addr_q == OFF_MEM_BASE
        |-> o_cfg_rdata[11:0] == 12'h000)
        else $error("mem base low bits set");

    rom_reset_clear_a: assert property (@(posedge i_clk) // RULE_03
        $rose(rst_n) |-> rom_base_q == '0 && !rom_enable_q)
        else $error("rom reg not cleared");

    rom_size_bits_a: assert property (@(posedge i_clk) disable iff (!rst_n) // RULE_04
        o_cfg_ack && $past(i_cfg_rd) && cfg_addr_q == OFF_ROM_BASE
        |-> o_cfg_rdata[14:1] == 14'h0000)
        else $error("rom size bits not zero");

    no_claim_a: assert property (@(posedge i_clk) disable iff (!rst_n) // RULE_05
        start && !(rom_enable_q && i_mem_space_en) |=> o_devsel_n [*2])
        else $error("claimed while disabled");

    alias_abort_a: assert property (@(posedge i_clk) disable iff (!rst_n) // RULE_06
        st_q == ST_CLAIM && alias_hit |=> !o_stop_n && o_devsel_n)
        else $error("alias not aborted");

    trdy_hold_a: assert property (@(posedge i_clk) disable iff (!rst_n) // RULE_07
        $fell(o_trdy_n) |-> $past(seq_done))
        else $error("early trdy");

    read_disconnect_a: assert property (@(posedge i_clk) disable iff (!rst_n) // RULE_09
        !o_trdy_n |-> !o_stop_n && !o_devsel_n)
        else $error("no disconnect");

    multi_be_abort_a: assert property (@(posedge i_clk) disable iff (!rst_n) // RULE_11
        st_q == ST_CLAIM && !i_irdy_n && be_bad
        |=> st_q == ST_ABORT && !o_mp_req)
        else $error("multi lane write kept");

    fixed_ids_a: assert property (@(posedge i_clk) disable iff (!rst_n) // RULE_14
        o_cfg_ack && $past(i_cfg_rd) && cfg_addr_q == OFF_IRQ
        |-> o_cfg_rdata[31:8] == 24'h08_0801)
        else $error("fixed values wrong");

endmodule // pcr_config_rom

// ===== hdl/pcr_pkg.sv
// Functional notes
// (RULE_01) memory base bits 31-12 read/write, 4096-byte placement
// (RULE_02) memory base bits 11-00 always read zero
// (RULE_03) rom base/enable clears to zero during bus reset
// (RULE_04) rom base bits 31-15 read/write; bits 14-01 always read zero
// (RULE_05) claim rom cycles only with rom and memory space enabled
// (RULE_06) rom enabled and memory base equal to rom base: target-abort
// (RULE_07) rom read fetches four bytes, trdy held off until assembled
// (RULE_08) first fetched byte lands in bits 7-0, fourth in 31-24
// (RULE_09) every rom read data phase is disconnected
// (RULE_10) rom write derives low address from byte enable, one byte, disconnect
// (RULE_11) rom write with other than one byte enable ends in target-abort
// (RULE_12) software should clear memory space enable while setting rom enable
// (RULE_13) interrupt line is an 8-bit read/write store, reset zero
// (RULE_14) interrupt pin register always reads 01h
// (RULE_15) minimum grant register always reads 08h
// (RULE_16) maximum latency reads 08h; any latency timer setting works
// (RULE_17) block works with any grant duration as bus master
// (RULE_18) feature config is 8-bit read/write, cleared only by bus reset
// (RULE_19) writes to fixed bits dropped; reads return fixed values
package pcr_pkg;

    // ************************************************************
    // configuration offsets
    // ************************************************************
    localparam logic [7:0] OFF_MEM_BASE = 8'h14;
    localparam logic [7:0] OFF_ROM_BASE = 8'h30;
    localparam logic [7:0] OFF_IRQ = 8'h3C;
    localparam logic [7:0] OFF_FEATURE = 8'h40;

    // ************************************************************
    // field layout
    // ************************************************************
    localparam int MEM_BASE_LSB = 12;
    localparam int ROM_BASE_LSB = 15;
    localparam int ROM_DEC_LSB = 16;
    localparam int ROM_ADDR_W = 16;
    localparam int FC_SPARE = 7;
    localparam int FC_MEM_READ_CMD = 6;
    localparam int FC_SLOW_TIMING = 5;
    localparam int FC_PARITY_EN = 4;
    localparam int FC_PARITY_FORCE = 3;
    localparam int FC_DUAL_ADDR = 2;
    localparam int FC_TERM_POL = 1;

    // ************************************************************
    // reset and fixed values
    // ************************************************************
    localparam logic [19:0] MEM_BASE_RST = 20'h0_0000;
    localparam logic [16:0] ROM_BASE_RST = 17'h0_0000;
    localparam logic [7:0] IRQ_LINE_RST = 8'h00;
    localparam logic [7:0] FEATURE_RST = 8'h00;
    localparam logic [7:0] IRQ_PIN_VALUE = 8'h01;
    localparam logic [7:0] MIN_GNT_VALUE = 8'h08;
    localparam logic [7:0] MAX_LAT_VALUE = 8'h08;

    // ************************************************************
    // bus commands
    // ************************************************************
    localparam logic [3:0] CMD_MEM_RD = 4'h6;
    localparam logic [3:0] CMD_MEM_WR = 4'h7;
    localparam logic [3:0] CMD_MEM_RD_MULT = 4'hC;
    localparam logic [3:0] CMD_MEM_RD_LINE = 4'hE;
    localparam logic [3:0] CMD_MEM_WR_INV = 4'hF;

    // ************************************************************
    // target state machine
    // ************************************************************
    typedef enum logic [5:0] {
        ST_IDLE  = 6'b00_0001,
        ST_CLAIM = 6'b00_0010,
        ST_WAIT  = 6'b00_0100,
        ST_XFER  = 6'b00_1000,
        ST_STOPW = 6'b01_0000,
        ST_ABORT = 6'b10_0000
    } pcr_state_t;

endpackage

// ===== hdl/pcr_rom_seq.sv
`timescale 1ns/1ps
// byte sequencer for the external rom on the memory port
module pcr_rom_seq
    import pcr_pkg::*;
(
    input wire logic i_clk, // bus clock
    input wire logic i_rst_n, // synchronised reset, active low
    input wire logic i_start, // start pulse
    input wire logic i_write, // 1 = single byte write
    input wire logic [ROM_ADDR_W-1:2] i_addr, // dword address
    input wire logic [1:0] i_lane, // byte lane for writes
    input wire logic [7:0] i_wdata, // write byte
    output logic o_done, // done pulse
    output logic [31:0] o_rdata, // assembled read word
    output logic o_mp_req, // request, level
    output logic o_mp_we, // memory port write
    output logic [ROM_ADDR_W-1:0] o_mp_addr, // byte address
    output logic [7:0] o_mp_wdata, // write byte
    input wire logic i_mp_ack, // byte done, pulse
    input wire logic [7:0] i_mp_rdata // read byte
);
    logic busy_q;
    logic [1:0] cnt_q;

    // held to the last byte; arbitration may stretch it
    assign o_mp_req = busy_q;

    // ************************************************************
    // byte walk
    // ************************************************************
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            busy_q <= 1'b0;
            cnt_q <= 2'd0;
            o_done <= 1'b0;
            o_mp_we <= 1'b0;
            o_mp_addr <= '0;
            o_mp_wdata <= 8'h00;
        end else begin
            o_done <= 1'b0;
            if (i_start) begin
                busy_q <= 1'b1;
                cnt_q <= 2'd0;
                o_mp_we <= i_write;
                o_mp_wdata <= i_wdata;
                // reads start at byte 0, writes at the enabled lane
                o_mp_addr <= {i_addr, i_write ? i_lane : 2'b00}; // RULE_07 RULE_10
            end else if (busy_q && i_mp_ack) begin
                if (o_mp_we || cnt_q == 2'd3) begin
                    busy_q <= 1'b0;
                    o_done <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 2'd1;
                    o_mp_addr[1:0] <= cnt_q + 2'd1; // RULE_07
                end
            end
        end
    end

    // ************************************************************
    // assembly: byte n of the walk lands in lane n
    // ************************************************************
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= 32'h0000_0000;
        end else if (busy_q && i_mp_ack && !o_mp_we) begin
            o_rdata[cnt_q*8 +: 8] <= i_mp_rdata; // RULE_08
        end
    end

endmodule // pcr_rom_seq

// ===== testbench/pcr_rom_model.sv
`timescale 1ns/1ps
// ********************
// byte-wide rom behind the memory port
// ********************
module pcr_rom_model (
    input wire logic i_clk, // bus clock
    input wire logic i_req, // byte request, level
    input wire logic i_we, // write qualifier
    input wire logic [15:0] i_addr, // byte address
    input wire logic [7:0] i_wdata, // write byte
    input wire logic [1:0] i_dly, // wait cycles per byte
    output logic o_ack, // byte done, pulse
    output logic [7:0] o_rdata // read byte, valid with ack
);
    logic [7:0] mem [0:65535];
    logic [2:0] cnt_q = 3'd0;
    // neighbours differ so lane slips show
    initial begin
        for (int i = 0; i < 65536; i++) mem[i] = 8'(i * 37 + (i >> 8));
        o_ack = 1'b0;
        o_rdata = 8'h00;
    end
    // data toggles off ack to expose stale samples
    always @(posedge i_clk) begin
        o_ack <= 1'b0;
        o_rdata <= ~o_rdata;
        if (i_req && !o_ack) begin
            if (cnt_q >= {1'b0, i_dly}) begin
                o_ack <= 1'b1;
                cnt_q <= 3'd0;
                if (i_we) begin
                    mem[i_addr] <= i_wdata;
                end else begin
                    o_rdata <= mem[i_addr];
                end
            end else begin
                cnt_q <= cnt_q + 3'd1;
            end
        end
    end
endmodule // pcr_rom_model

// ===== testbench/tb_pcr_config_rom.sv
`timescale 1ns/1ps
module tb_pcr_config_rom;
    import pcr_pkg::*;
    logic i_clk = 1'b0, i_nrst = 1'b0, i_cfg_wr = 1'b0, i_cfg_rd = 1'b0;
    logic i_mem_space_en = 1'b0, i_frame_n = 1'b1, i_irdy_n = 1'b1;
    logic [7:0] i_cfg_addr = 8'h00, o_mp_wdata, i_mp_rdata, o_irq_line_value;
    logic [3:0] i_cfg_be = 4'h0, i_cbe_n = 4'hF;
    logic [31:0] i_cfg_wdata = '0, i_ad = '0, o_cfg_rdata, o_ad;
    logic o_cfg_ack, o_ad_oe, o_devsel_n, o_trdy_n, o_stop_n, o_tgt_oe;
    logic o_mp_req, o_mp_we, i_mp_ack;
    logic [15:0] o_mp_addr;
    logic [31:12] o_mem_base_bits;
    logic [5:0] feat;
    logic [1:0] dly = 2'd0;
    logic [31:0] seed = 32'd48933;
    logic [31:0] sh [5];
    int n_mismatch = 0, n_compared = 0;
    localparam logic [7:0] ADDRS [5] = '{OFF_MEM_BASE, OFF_ROM_BASE, OFF_IRQ,
        OFF_FEATURE, 8'h20};
    localparam logic [31:0] WM [5] = '{32'hFFFF_F000, 32'hFFFF_8001,
        32'h0000_00FF, 32'h0000_00FF, 32'h0000_0000};
    localparam logic [31:0] FX [5] = '{32'h0000_0000, 32'h0000_0000,
        32'h0808_0100, 32'h0000_0000, 32'h0000_0000};
    localparam logic [3:0] CMDS [5] = '{CMD_MEM_RD, CMD_MEM_RD_MULT,
        CMD_MEM_RD_LINE, CMD_MEM_WR, CMD_MEM_WR_INV};
    pcr_config_rom DUT (.*, .o_mem_read_cmd_en(feat[5]),
        .o_ext_block_slow_timing(feat[4]), .o_ext_block_parity_en(feat[3]),
        .o_parity_test_force(feat[2]), .o_dual_addr_en(feat[1]),
        .o_term_power_polarity(feat[0]));
    pcr_rom_model u_rom (.i_clk(i_clk), .i_req(o_mp_req), .i_we(o_mp_we),
        .i_addr(o_mp_addr), .i_wdata(o_mp_wdata), .i_dly(dly),
        .o_ack(i_mp_ack), .o_rdata(i_mp_rdata));
    // 8 ns clock
    always #4 i_clk = ~i_clk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic int idx(input logic [7:0] a);
        for (int i = 0; i < 4; i++) if (ADDRS[i] == a) return i;
        return 4;
    endfunction
    // first rom byte lands in the low lane
    function automatic logic [31:0] rom_word(input logic [31:0] a);
        logic [15:0] b;
        b = {a[15:2], 2'b00};
        return {u_rom.mem[b+3], u_rom.mem[b+2], u_rom.mem[b+1], u_rom.mem[b]};
    endfunction
    task automatic chk(input logic [31:0] got, exp, input string what);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ********************
    // configuration port
    // ********************
    task automatic cfg(input logic wr, input logic [7:0] a,
                       input logic [3:0] be, input logic [31:0] wd);
        @(negedge i_clk);
        i_cfg_wr = wr;
        i_cfg_rd = !wr;
        i_cfg_addr = a;
        i_cfg_be = be;
        i_cfg_wdata = wd;
        @(negedge i_clk);
        i_cfg_wr = 1'b0;
        i_cfg_rd = 1'b0;
        chk({31'd0, o_cfg_ack}, 32'd1, "ack");
    endtask
    // shadow holds writable bits only
    task automatic reg_wr(input logic [7:0] a, input logic [3:0] be,
                          input logic [31:0] wd);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & WM[idx(a)];
        sh[idx(a)] = (sh[idx(a)] & ~m) | (wd & m);
        cfg(1'b1, a, be, wd);
        chk({o_mem_base_bits, feat, 6'd0}, {sh[0][31:12], sh[3][6:1], 6'd0},
            "outs");
        chk({24'd0, o_irq_line_value}, sh[2] & 32'h0000_00FF, "irq");
    endtask
    task automatic reg_rd(input logic [7:0] a);
        cfg(1'b0, a, 4'hF, rnd());
        chk(o_cfg_rdata, sh[idx(a)] | FX[idx(a)], "read");
    endtask
    task automatic read_all();
        for (int i = 0; i < 5; i++) reg_rd(ADDRS[i]);
    endtask
    // ********************
    // bus initiator; code 0 ignored, 1 data+stop, 2 abort, 3 no stop
    // ********************
    task automatic bus(input logic [3:0] cmd, input logic burst,
                       input logic [31:0] a, input logic [3:0] be_n,
                       input logic [31:0] wd, output int code,
                       output logic [31:0] rd);
        bit seen = 0;
        code = 0;
        rd = '0;
        dly = rnd() % 4;
        @(negedge i_clk);
        i_frame_n = 1'b0;
        i_ad = a;
        i_cbe_n = cmd;
        @(negedge i_clk);
        i_frame_n = !burst;
        i_irdy_n = 1'b0;
        i_cbe_n = be_n;
        i_ad = wd;
        for (int n = 0; n < 60 && code == 0; n++) begin
            @(negedge i_clk);
            seen |= !o_devsel_n;
            if (!o_trdy_n && !o_devsel_n) begin
                code = o_stop_n ? 3 : 1;
                rd = o_ad;
            end else if (!o_stop_n && o_devsel_n) begin
                code = 2;
            end
        end
        if (code == 0 && seen) code = 4;
        i_frame_n = 1'b1;
        @(negedge i_clk);
        i_irdy_n = 1'b1;
        i_ad = rnd();
        repeat (2) @(negedge i_clk);
    endtask
    // main sequence
    initial begin
        int code, k;
        logic [31:0] rd, a, rb, v;
        sh = '{default: '0};
        repeat (8) @(negedge i_clk);
        i_nrst = 1'b1;
        repeat (4) @(negedge i_clk);
        read_all();
        for (int i = 0; i < 5; i++) reg_wr(ADDRS[i], 4'hF, 32'hFFFF_FFFF);
        read_all();
        repeat (30) begin
            v = rnd();
            a = ADDRS[v % 5];
            reg_wr(a, v[7:4], rnd());
            reg_rd(a);
        end
        // rom enable set with memory space off
        i_mem_space_en = 1'b0;
        rb = {rnd() & 32'hFFFF_0000};
        reg_wr(OFF_ROM_BASE, 4'hF, rb | 32'h0000_0001);
        reg_wr(OFF_MEM_BASE, 4'hF, rb ^ 32'h0001_0000);
        bus(CMD_MEM_RD, 1'b0, rb, 4'h0, rnd(), code, rd);
        chk(code, 0, "mem off");
        i_mem_space_en = 1'b1;
        for (int i = 0; i < 12; i++) begin
            a = rb | (rnd() & 32'h0000_FFFF);
            bus(CMDS[i % 3], i[0], a, rnd(), rnd(), code, rd);
            chk(code, 1, "rd end");
            chk(rd, rom_word(a), "rd data");
        end
        for (int i = 0; i < 8; i++) begin
            a = rb | (rnd() & 32'h0000_FFFC);
            v = rom_word(a);
            k = i % 4;
            v[8*k +: 8] = 8'(rnd());
            bus(CMDS[3 + i % 2], i[2], a, ~(4'b1 << k), v, code, rd);
            chk(code, 1, "wr end");
            bus(CMD_MEM_RD, 1'b0, a, 4'h0, rnd(), code, rd);
            chk(rd, v, "wr lane");
        end
        bus(CMD_MEM_WR, 1'b0, rb, 4'hC, rnd(), code, rd);
        chk(code, 2, "two lanes");
        bus(CMD_MEM_WR, 1'b0, rb, 4'hF, rnd(), code, rd);
        chk(code, 2, "no lane");
        bus(CMD_MEM_RD, 1'b0, rb ^ 32'h0100_0000, 4'h0, 0, code, rd);
        chk(code, 0, "outside");
        reg_wr(OFF_MEM_BASE, 4'hF, rb);
        bus(CMD_MEM_RD, 1'b0, rb | 32'h0000_0104, 4'h0, 0, code, rd);
        chk(code, 2, "alias abort");
        reg_wr(OFF_ROM_BASE, 4'h1, 32'h0000_0000);
        bus(CMD_MEM_RD, 1'b0, rb, 4'h0, 0, code, rd);
        chk(code, 0, "rom off");
        // mid-run reset clears all
        i_nrst = 1'b0;
        sh = '{default: '0};
        repeat (3) @(negedge i_clk);
        i_nrst = 1'b1;
        repeat (4) @(negedge i_clk);
        read_all();
        stop_test();
    end
endmodule // tb_pcr_config_rom
